//--- logic/indicator_consts.vh
// Constants for the status indicator and reset pin block.
// Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef INDICATOR_CONSTS_VH
`define INDICATOR_CONSTS_VH
`define CLK_HZ 20000000
`define RST_MIN_MS 100
// Counts are sized to the counters they load
// Minimum pull: CLK_HZ / 1000 * RST_MIN_MS
`define RST_MIN_CYC 25'h1e8480
`define INT_RST_CYC 5'h10
`define FAST_HZ 3
`define SLOW_HZ 1
// Half periods: CLK_HZ / (2 * rate)
`define FAST_HALF_CYC 25'h32dcd5
`define SLOW_HALF_CYC 25'h989680
`define PULSE_HALF_CYC 25'h1e8480
`define ACT_HALF_CYC 25'h0f4240
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STAT 8'h08
`define OFF_IRQ_MASK 8'h0c
`define OFF_UPTIME 8'h10
`define OFF_FAULT0 8'h20
`define FAULT_DEPTH 5
`define CTRL_RST 8'h00
`define CTRL_BOOTED 0
`define CTRL_CONFLICT_EN 1
`define CTRL_SELFTEST_OK 2
`define CTRL_SELFTEST_DONE 3
`define CTRL_SWRESET 4
`define CTRL_CLR_SERIAL 5
`define EV_FRAME 0
`define EV_OVERRUN 1
`define EV_FLOW 2
`define EV_CONFLICT 3
`define EV_SELFTEST 4
`define EV_EXTRST 5
`endif

//--- logic/blink_gen.v
// Square-wave blink generator with a programmable half period.
// Assumes the half period is a constant at least one cycle long.
`timescale 1ns/1ps
`default_nettype none
module blink_gen #(
   parameter [24:0] HALF = 25'd10
) (
   input wire hclk,
   input wire hresetn,
   input wire run,
   output reg wave
);
   reg [24:0] count; // Cycles elapsed in this half period

   // Toggle the wave at each half period; hold low while stopped
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 25'h0000000;
         wave <= 1'b0;
      end else if (!run) begin
         count <= 25'h0000000;
         wave <= 1'b0;
      end else if (count == HALF - 25'h0000001) begin
         count <= 25'h0000000;
         wave <= ~wave;
      end else begin
         count <= count + 25'h0000001;
      end
   end
endmodule // blink_gen
`default_nettype wire

//--- logic/status_indicator.v
// Status indicators, shared reset pin, modem line defaults and fault log.
// Assumes one 20 MHz clock, AHB-Lite master, and raw pins from outside.
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`include "indicator_consts.vh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - Reset pin low 100 ms restarts
// - Drive reset pin low on internal reset
// - Status fast flash while booting or unaddressed
// - Status slow flash while connected
// - Error fast flash on address conflict
// - Double flash after serial format errors
// - Triple flash after ignored flow stop
// - Self-test failure lights all but power, halts
// - Log last five faults with uptime
// - Speed indicator on for 100 Mbit
// - Link indicator on with valid link
// - Link indicator flashes on traffic
// - Power indicator on with supply
// - DTR and RTS driven asserted low
// - Ignore handshake inputs, use receive data
module status_indicator #(
   parameter [24:0] RST_MIN_CYC = `RST_MIN_CYC,
   parameter [24:0] FAST_HALF = `FAST_HALF_CYC,
   parameter [24:0] SLOW_HALF = `SLOW_HALF_CYC,
   parameter [24:0] PULSE_HALF = `PULSE_HALF_CYC,
   parameter [24:0] ACT_HALF = `ACT_HALF_CYC
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   output reg irq,
   input wire reset_pin_in,
   output reg reset_pin_out,
   output reg reset_pin_oe,
   output reg restart_req,
   input wire power_good,
   input wire ip_assigned,
   input wire port_connected,
   input wire conflict_seen,
   input wire rx_frame_err,
   input wire rx_overrun,
   input wire rx_after_stop,
   input wire eth_link,
   input wire eth_speed100,
   input wire eth_activity,
   input wire uart_rxd,
   input wire uart_cts,
   input wire uart_dsr,
   input wire uart_dcd,
   input wire uart_ri,
   output reg uart_dtr,
   output reg uart_rts,
   output reg rx_data,
   output reg led_power,
   output reg led_status,
   output reg led_error,
   output reg led_speed,
   output reg led_link
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Every pin below may change at any moment relative to hclk, so two
   // flip-flops stand between it and the logic. The price is two cycles of
   // lag on the power, speed and link lamps, far below anything the eye can see.
   reg [5:0] sync_a; // First stage, read only by the second stage
   reg [5:0] sync_b; // Second stage, safe to use
   // Async pins: reset, power, link, speed and activity, receive data
   // Reset to the pins' idle levels, so no false lamp flash follows reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_a <= 6'h38;
         sync_b <= 6'h38;
      end else begin
         sync_a <= {uart_rxd, reset_pin_in, power_good, eth_link, eth_speed100, eth_activity};
         sync_b <= sync_a;
      end
   end
   wire s_rxd = sync_b[5]; // Receive data; handshake inputs are never sampled
   wire s_rst = sync_b[4]; // Shared reset pin, low = pulled
   wire s_pwr = sync_b[3]; // Supply present
   wire s_link = sync_b[2]; // Link pulse seen
   wire s_spd = sync_b[1]; // 100 Mbit link
   wire s_act = sync_b[0]; // Packet traffic

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg [7:0] ctrl; // Software control bits
   reg [5:0] irq_stat; // Sticky event bits, write one to clear
   reg [5:0] irq_mask; // Interrupt enables
   reg [31:0] uptime; // Cycles since last restart
   reg [2:0] serial_err; // Latched: format, flow
   reg [31:0] fault_time [0:4]; // Fault log time stamps
   reg [2:0] fault_code [0:4]; // Fault log codes
   reg [2:0] fault_wr; // Next log slot
   reg [24:0] low_cnt; // Reset pin low duration
   reg [4:0] int_rst_cnt; // Internal reset pulse stretch
   reg a_valid; // Data phase pending
   reg a_write; // Pending phase is a write
   reg [7:0] a_addr; // Offset of the pending phase
   // Control bits come from software: boot code marks itself booted and
   // reports the self-test result; this block only shows them
   wire booted = ctrl[`CTRL_BOOTED];
   wire st_done = ctrl[`CTRL_SELFTEST_DONE];
   wire st_fail = st_done & ~ctrl[`CTRL_SELFTEST_OK];
   wire conflict = ctrl[`CTRL_CONFLICT_EN] & conflict_seen;
   wire fmt_ev = rx_frame_err | rx_overrun;
   // One bit per sticky event, in the order of the event register
   wire ext_rst_ev = (low_cnt == RST_MIN_CYC - 25'h0000001); // Long outside pull completes
   wire [5:0] events = {ext_rst_ev, st_fail, conflict, rx_after_stop, rx_overrun, rx_frame_err};
   wire wr_data = a_valid & a_write;
   wire clr_serial = wr_data & (a_addr == `OFF_CTRL) & hwdata[`CTRL_CLR_SERIAL];
   wire sw_reset = wr_data & (a_addr == `OFF_CTRL) & hwdata[`CTRL_SWRESET];

   // hreadyout and hresp keep their reset values: every access completes
   // in a single data phase cycle and the answer is always OKAY
   // Address phase capture; slave is always ready with OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_valid <= 1'b0;
         a_write <= 1'b0;
         a_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (hready) begin
         a_valid <= hsel & htrans[1];
         a_write <= hwrite;
         a_addr <= haddr[7:0];
      end
   end

   // Software clears a sticky bit by writing one; an event in that same
   // cycle keeps it set, so no event is ever lost
   // Bits 4 and 5 of control are strobes: they act in the write cycle only
   // Control, mask, status write-one-clear; set wins over clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `CTRL_RST;
         irq_mask <= 6'h00;
         irq_stat <= 6'h00;
      end else begin
         if (wr_data & (a_addr == `OFF_CTRL))
            ctrl <= {2'h0, 2'h0, hwdata[3:0]};
         if (wr_data & (a_addr == `OFF_IRQ_MASK))
            irq_mask <= hwdata[5:0];
         if (wr_data & (a_addr == `OFF_IRQ_STAT))
            irq_stat <= (irq_stat & ~hwdata[5:0]) | events;
         else
            irq_stat <= irq_stat | events;
      end
   end

   // Register map, one word each:
   //   0x00 control: booted, conflict watch, self-test ok, self-test done,
   //        write-one internal reset pulse, write-one serial error clear
   //   0x04 status: power, booted, format, flow, conflict, self-test fail,
   //        100 Mbit, link
   //   0x08 sticky events, write one to clear; 0x0c their interrupt mask
   //   0x10 cycles since restart
   //   0x20 + 8k time of fault k, 0x24 + 8k its code {flow, overrun, frame}
   // Unmapped offsets read zero and ignore writes; hsize is not checked.
   // Strobe bits of control always read back as zero.
   wire [7:0] fault_off = haddr[7:0] - `OFF_FAULT0; // Offset inside the log window
   wire [2:0] fault_sel = fault_off[5:3]; // Slot, two words per slot
   // Read data, registered into the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
         if (hready & hsel & htrans[1] & ~hwrite) begin
            if (haddr[7:0] == `OFF_CTRL)
               hrdata <= {24'h000000, ctrl};
            else if (haddr[7:0] == `OFF_STATUS)
               hrdata <= {24'h000000, s_link, s_spd, st_fail, conflict, serial_err[1:0], booted, s_pwr};
            else if (haddr[7:0] == `OFF_IRQ_STAT)
               hrdata <= {26'h0000000, irq_stat};
            else if (haddr[7:0] == `OFF_IRQ_MASK)
               hrdata <= {26'h0000000, irq_mask};
            else if (haddr[7:0] == `OFF_UPTIME)
               hrdata <= uptime;
            else if (haddr[7:0] >= `OFF_FAULT0 && haddr[7:0] < 8'h48) begin
               // Even word of a slot holds the stamp, odd word the code
               if (haddr[2])
                  hrdata <= {29'h0, fault_code[fault_sel]};
               else
                  hrdata <= fault_time[fault_sel];
            end else
               hrdata <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial error latches and fault log
   // The log is a ring of five slots: the oldest entry is overwritten, so
   // software always sees the five most recent faults.
   // Uptime wraps after 2^32 cycles, so very old stamps are ambiguous.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_err <= 3'h0;
         uptime <= 32'h00000000;
         fault_wr <= 3'h0;
         fault_time[0] <= 32'h00000000;
         fault_time[1] <= 32'h00000000;
         fault_time[2] <= 32'h00000000;
         fault_time[3] <= 32'h00000000;
         fault_time[4] <= 32'h00000000;
         fault_code[0] <= 3'h0;
         fault_code[1] <= 3'h0;
         fault_code[2] <= 3'h0;
         fault_code[3] <= 3'h0;
         fault_code[4] <= 3'h0;
      end else begin
         uptime <= uptime + 32'h00000001;
         // Set wins over a software clear in the same cycle
         serial_err <= (clr_serial ? 3'h0 : serial_err) | {1'b0, rx_after_stop, fmt_ev};
         if (fmt_ev | rx_after_stop) begin
            fault_time[fault_wr] <= uptime;
            fault_code[fault_wr] <= {rx_after_stop, rx_overrun, rx_frame_err};
            fault_wr <= (fault_wr == 3'h4) ? 3'h0 : fault_wr + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset pin: long low detect and internal reset drive
   // The pin is open collector: reset_pin_out stays low and only the enable
   // moves, so the pin is never driven high against an outside pull.
   // restart_req is only a request; the power-on logic around this block
   // performs the restart itself.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt <= 25'h0000000;
         int_rst_cnt <= 5'h00;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b1;
         restart_req <= 1'b0;
      end else begin
         // Own drive is ignored, so a self reset never counts as an outside request
         if (s_rst | reset_pin_oe)
            low_cnt <= 25'h0000000;
         else if (low_cnt != RST_MIN_CYC)
            low_cnt <= low_cnt + 25'h0000001;
         restart_req <= (low_cnt == RST_MIN_CYC - 25'h0000001);
         if (sw_reset)
            int_rst_cnt <= `INT_RST_CYC;
         else if (int_rst_cnt != 5'h00)
            int_rst_cnt <= int_rst_cnt - 5'h01;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= sw_reset | (int_rst_cnt > 5'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Blink sources
   // The traffic source runs only while packets are seen, so an idle link rests lit
   wire fast_w, slow_w, pulse_w, act_w;
   blink_gen #(.HALF(FAST_HALF)) u_fast (.hclk(hclk), .hresetn(hresetn), .run(1'b1), .wave(fast_w));
   blink_gen #(.HALF(SLOW_HALF)) u_slow (.hclk(hclk), .hresetn(hresetn), .run(1'b1), .wave(slow_w));
   blink_gen #(.HALF(PULSE_HALF)) u_pulse (.hclk(hclk), .hresetn(hresetn), .run(1'b1), .wave(pulse_w));
   blink_gen #(.HALF(ACT_HALF)) u_act (.hclk(hclk), .hresetn(hresetn), .run(s_act), .wave(act_w));

   // Group sequencer: counts pulse half periods, sixteen per group
   reg pulse_d;
   reg [3:0] slot; // Half-period index inside a group
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_d <= 1'b0;
         slot <= 4'h0;
      end else begin
         pulse_d <= pulse_w;
         if (pulse_d != pulse_w)
            slot <= slot + 4'h1;
      end
   end
   // A group lasts sixteen pulse half periods; the first 2n carry n flashes
   // and the rest are the pause that separates one group from the next
   // Flash n times: on during even slots below 2n, then a pause
   wire dbl = (slot < 4'h4) & ~slot[0];
   wire tpl = (slot < 4'h6) & ~slot[0];

   ////////////////////////////////////////////////////////////////////////////
   // Indicator and modem line drive
   // Error lamp priority, highest first: address conflict, ignored flow stop,
   // format or overrun. A self-test failure overrides every lamp but power.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // All lamps dark while held in reset
         led_power <= 1'b0;
         led_status <= 1'b0;
         led_error <= 1'b0;
         led_speed <= 1'b0;
         led_link <= 1'b0;
         uart_dtr <= 1'b0;
         uart_rts <= 1'b0;
         rx_data <= 1'b1;
      end else begin
         // No-handshake mode: DTR and RTS sit at 0 V, which means asserted
         uart_dtr <= 1'b0;
         uart_rts <= 1'b0;
         rx_data <= s_rxd;
         led_power <= s_pwr;
         if (st_fail) begin
            // Halted: every lamp but power lit
            led_status <= 1'b1;
            led_error <= 1'b1;
            led_speed <= 1'b1;
            led_link <= 1'b1;
         end else begin
            if (!booted | !ip_assigned)
               led_status <= fast_w;
            else if (port_connected)
               led_status <= slow_w;
            else
               led_status <= 1'b0;
            if (conflict)
               led_error <= fast_w;
            else if (serial_err[1])
               led_error <= tpl;
            else if (serial_err[0])
               led_error <= dbl;
            else
               led_error <= 1'b0;
            led_speed <= s_link & s_spd;
            led_link <= s_link & ~(s_act & act_w);
         end
      end
   end
endmodule // status_indicator
`default_nettype wire

//--- testbench/indicator_monitor.sv
// Port checker for status_indicator, bound below.
// Assumes shortened counts handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module indicator_monitor #(
   parameter [24:0] RST_MIN_CYC = 25'd20,
   parameter [24:0] FAST_HALF = 25'd4
) (
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire reset_pin_in,
   input wire reset_pin_out,
   input wire reset_pin_oe,
   input wire restart_req,
   input wire power_good,
   input wire ip_assigned,
   input wire eth_link,
   input wire eth_speed100,
   input wire uart_dtr,
   input wire uart_rts,
   input wire led_power,
   input wire led_status,
   input wire led_link,
   input wire led_speed
);
   reg [24:0] low_cnt; // Length of an outside pull
   reg [24:0] hold; // Dwell of status lamp while unaddressed
   reg last_st; // Status lamp one cycle ago
   ////////////////////
   // Own drive is not a press, so it clears the count
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt <= 25'h0;
         hold <= 25'h0;
         last_st <= 1'b0;
      end else begin
         last_st <= led_status;
         low_cnt <= (reset_pin_in || reset_pin_oe) ? 25'h0 : low_cnt + 25'h1;
         hold <= (ip_assigned || led_status != last_st) ? 25'h0 : hold + 25'h1;
      end
   end
   ////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   pin_sink_a: assert property (!reset_pin_out) else $error("pin driven high");
   restart_long_a: assert property (restart_req |-> low_cnt >= RST_MIN_CYC) else $error("early restart");
   power_lamp_a: assert property (power_good [*5] |-> led_power) else $error("power lamp dark");
   speed_lamp_a: assert property ((eth_link && eth_speed100) [*5] |-> led_speed) else $error("speed dark");
   link_dark_a: assert property ((!eth_link) [*5] |-> !led_link) else $error("link lamp lit");
   boot_blink_a: assert property (hold < FAST_HALF + 25'd6) else $error("status not flashing");
   modem_low_a: assert property (!uart_dtr && !uart_rts) else $error("modem line high");
   cover property (restart_req);
   cover property ($rose(reset_pin_oe));
   cover property (led_speed && led_link);
endmodule // indicator_monitor
bind status_indicator indicator_monitor #(.RST_MIN_CYC(RST_MIN_CYC), .FAST_HALF(FAST_HALF)) mon (.*);
`default_nettype wire

//--- testbench/uart_peer.sv
// Serial peripheral on the logic-level header.
// Assumes a pull-up on the shared reset pin.
`timescale 1ns/1ps
`default_nettype none
module uart_peer (
   input wire logic hclk,
   input wire logic pin_oe,
   input wire logic pin_out,
   input wire logic tx_bit,
   output logic pin,
   output logic rxd,
   output logic [3:0] hs
);
   logic pull = 1'b0; // Pushbutton open
   logic [3:0] spin = 4'h5; // Churning handshake pattern
   // Wired pin: high unless either side sinks it
   assign pin = !(pull || (pin_oe && !pin_out));
   assign rxd = tx_bit;
   assign hs = spin;
   // Handshake lines change every cycle; device must not care
   always @(posedge hclk) begin
      spin <= ~spin;
   end
   // Hold the pin at ground for n cycles
   task automatic press(input int n);
      @(posedge hclk);
      pull <= 1'b1;
      repeat (n) @(posedge hclk);
      pull <= 1'b0;
   endtask
endmodule // uart_peer
`default_nettype wire

//--- testbench/status_indicator_tb.sv
// Bench for status_indicator: bus tasks and lamp checks.
// Assumes zero-wait bus answers and shortened counts.
`timescale 1ns/1ps
`default_nettype none
module status_indicator_tb;
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, tx_bit = 1'b1, hsel = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0; // Transfer size, set with each address phase
   logic [2:0] ev = 3'h0; // Frame, overrun, flow pulses
   logic power_good = 1'b1, ip_assigned = 1'b0, port_connected = 1'b0, conflict_seen = 1'b0;
   logic eth_link = 1'b0, eth_speed100 = 1'b0, eth_activity = 1'b0;
   wire [31:0] hrdata;
   wire [3:0] hs;
   wire hreadyout, hresp, irq, reset_pin_in, reset_pin_out, reset_pin_oe, restart_req, uart_rxd;
   wire uart_dtr, uart_rts, rx_data, led_power, led_status, led_error, led_speed, led_link;
   wire [2:0] lamps = {led_link, led_error, led_status};
   int n_errors = 0, checked = 0, n_rst = 0, k = 0;
   always #25 hclk = ~hclk;
   always @(posedge hclk) if (restart_req === 1'b1) n_rst++;
   status_indicator #(.RST_MIN_CYC(25'd20), .FAST_HALF(25'd4), .SLOW_HALF(25'd8), .PULSE_HALF(25'd2),
      .ACT_HALF(25'd3)) dut (.*, .hready(hreadyout), .rx_frame_err(ev[0]),
      .rx_overrun(ev[1]), .rx_after_stop(ev[2]), .uart_cts(hs[0]), .uart_dsr(hs[1]), .uart_dcd(hs[2]),
      .uart_ri(hs[3]));
   uart_peer peer (.hclk(hclk), .pin_oe(reset_pin_oe), .pin_out(reset_pin_out), .tx_bit(tx_bit),
      .pin(reset_pin_in), .rxd(uart_rxd), .hs(hs));
   ////////////////////
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   // One single transfer; waits out any wait state
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      chk(nm, rd & m, e);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge hclk);
      ev <= v;
      @(posedge hclk);
      ev <= 3'h0;
   endtask
   // Count lamp changes over 64 cycles after settling
   task automatic tog(input int w, lo, hi, input string nm);
      int t;
      logic p;
      t = 0;
      repeat (8) @(posedge hclk);
      p = lamps[w];
      repeat (64) begin
         @(posedge hclk);
         t += (lamps[w] !== p);
         p = lamps[w];
      end
      chk(nm, t >= lo && t <= hi, 1);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////
   // Watchdog: whole run needs far fewer cycles
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge hclk);
      chk("oe in reset", reset_pin_oe, 1);
      hresetn <= 1'b1;
      tx_bit <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("oe idle", reset_pin_oe, 0);
      chk("modem", {uart_dtr, uart_rts}, 0);
      chk("rx data", rx_data, 0);
      chk("power", led_power, 1);
      tog(0, 15, 17, "boot flash");
      power_good <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("power off", led_power, 0);
      power_good <= 1'b1;
      $display("done: boot");
      conflict_seen <= 1'b1;
      tog(1, 0, 0, "conflict unwatched");
      chk("error dark", led_error, 0);
      ip_assigned <= 1'b1;
      port_connected <= 1'b1;
      bus(1'b1, 8'h00, 32'h3);
      tog(0, 7, 9, "slow flash");
      tog(1, 15, 17, "conflict flash");
      rdchk("conflict bit", 8'h04, 32'h10, 32'h10);
      port_connected <= 1'b0;
      tog(0, 0, 0, "status steady");
      chk("status dark", led_status, 0);
      conflict_seen <= 1'b0;
      pulse(3'h1);
      pulse(3'h2);
      tog(1, 7, 9, "double flash");
      rdchk("format bit", 8'h04, 32'hc, 32'h4);
      chk("irq masked", irq, 0);
      pulse(3'h4);
      tog(1, 11, 13, "triple flash");
      conflict_seen <= 1'b1;
      tog(1, 15, 17, "conflict first");
      conflict_seen <= 1'b0;
      for (int i = 0; i < 3; i++) rdchk("fault code", 8'h24 + 8 * i, 32'h7, 32'h1 << i);
      bus(1'b0, 8'h20, 32'h0);
      k = rd;
      bus(1'b0, 8'h28, 32'h0);
      chk("stamp order", rd > k, 1);
      pulse(3'h1);
      pulse(3'h2);
      pulse(3'h4);
      rdchk("ring wrap", 8'h24, 32'h7, 32'h4);
      rdchk("ring tail", 8'h44, 32'h7, 32'h2);
      hsel <= 1'b0;
      bus(1'b1, 8'h0c, 32'h3f);
      hsel <= 1'b1;
      rdchk("deselected", 8'h0c, 32'h3f, 32'h0);
      bus(1'b1, 8'h0c, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq on", irq, 1);
      bus(1'b1, 8'h08, 32'h3f);
      repeat (2) @(posedge hclk);
      chk("irq off", irq, 0);
      bus(1'b1, 8'h00, 32'h23);
      rdchk("serial clear", 8'h04, 32'hc, 32'h0);
      rdchk("unmapped", 8'h60, 32'hffffffff, 32'h0);
      $display("done: errors");
      peer.press(10);
      repeat (6) @(posedge hclk);
      chk("short press", n_rst, 0);
      peer.press(30);
      repeat (6) @(posedge hclk);
      chk("long press", n_rst, 1);
      rdchk("restart bit", 8'h08, 32'h20, 32'h20);
      bus(1'b1, 8'h00, 32'h13);
      k = 0;
      repeat (40) @(posedge hclk) k += reset_pin_oe;
      chk("own drive", k >= 14 && k <= 18, 1);
      chk("no self press", n_rst, 1);
      $display("done: reset pin");
      eth_link <= 1'b1;
      eth_speed100 <= 1'b1;
      repeat (6) @(posedge hclk);
      chk("fast link", {led_speed, led_link}, 2'h3);
      eth_speed100 <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("slow link", led_speed, 0);
      eth_activity <= 1'b1;
      tog(2, 8, 24, "traffic");
      eth_activity <= 1'b0;
      bus(1'b1, 8'h00, 32'h9);
      repeat (6) @(posedge hclk);
      chk("all lit", {led_power, led_status, led_error, led_speed, led_link}, 5'h1f);
      rdchk("test fail bit", 8'h04, 32'h20, 32'h20);
      $display("done: link and self-test");
      stop_test;
   end
endmodule // status_indicator_tb
`default_nettype wire
